// *** hw/id_page_pkg.sv ***
// package: constants, carriers and check-code helpers for the id page block
package id_page_pkg;

    localparam int PAGE_BYTES     = 128;
    localparam int GROUP_BYTES    = 4;
    localparam int GROUPS         = PAGE_BYTES / GROUP_BYTES;
    localparam int GROUP_BITS     = GROUP_BYTES * 8;
    localparam int ECC_BITS       = 6;
    localparam int ADDR_BITS      = 16;
    localparam int ADDR_SEL_BIT   = 10;
    localparam int LOCK_ARG_BIT   = 1;
    localparam int CLK_PERIOD_NS  = 4;
    localparam int WRITE_CYCLE_NS = 5_000_000;

    localparam logic [7:0]  CMD_SET_LATCH_DEF = 8'h0006;
    localparam logic [7:0]  CMD_WRITE_ID_DEF  = 8'h0082;
    localparam logic [7:0]  CMD_READ_LOCK_DEF = 8'h0083;
    localparam logic [7:0]  CMD_LOCK_ID_DEF   = 8'h0082;
    localparam logic [7:0]  ERASED_BYTE       = 8'h00FF;
    // identification code value is arbitrary
    localparam logic [23:0] ID_CODE_DEF       = 24'h5A_A53C;
    localparam logic [2:0]  LAST_BIT          = 3'h7;
    localparam logic [1:0]  HDR_DATA          = 2'h3;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic mosi;
    } spi_in_s;

    typedef struct packed {
        logic block_protect_high;
        logic block_protect_low;
    } protect_s;

    typedef struct packed {
        logic write_enable_latch;
        logic write_in_progress;
        logic page_locked;
    } status_s;

    // code word of data bit j: j-th value from 3 up that is no power of two
    function automatic logic [ECC_BITS-1:0] ecc_code(input int j);
        int n;
        ecc_code = '0;
        n = 0;
        for (int k = 3; k < 40; k++) begin
            if ((k & (k - 1)) != 0) begin
                if (n == j) ecc_code = ECC_BITS'(k);
                n++;
            end
        end
    endfunction

    function automatic logic [ECC_BITS-1:0] ecc_gen(input logic [GROUP_BITS-1:0] d);
        ecc_gen = '0;
        for (int j = 0; j < GROUP_BITS; j++) begin
            if (d[j]) ecc_gen ^= ecc_code(j);
        end
    endfunction

    // a single flipped check bit gives a power of two and leaves data alone
    function automatic logic [GROUP_BITS-1:0] ecc_fix(input logic [GROUP_BITS-1:0] d,
                                                      input logic [ECC_BITS-1:0]   c);
        logic [ECC_BITS-1:0] s;
        s = ecc_gen(d) ^ c;
        ecc_fix = d;
        for (int j = 0; j < GROUP_BITS; j++) begin
            if (s == ecc_code(j)) ecc_fix[j] = ~d[j];
        end
    endfunction

endpackage

// *** hw/id_page_ctrl.sv ***
// id page write, lock state read and page lock command handling
`timescale 1ns/100ps
// Notes on behaviour
// - write needs address bit ten clear
// - write cycle starts at select rise
// - first three bytes overwrite identification code
// - both protect bits set discards write and lock commands
// - busy or bad framing discards commands
// - lock read byte lsb shows lock
// - lock byte repeats while still selected
// - select high ends read, output released
// - lock read ignored during write cycle
// - lock only on exact byte boundary
// - lock is timed and permanent
// - power-on indication blocks all instructions
// - reset clears latch and busy flags
// - power-down indication resets and blocks device
// - output driven only while selected
// - reads correct single bit per group
// - single byte write rewrites whole group
// - delivered unlocked, erased apart from the identification code
// - write latch required before write/lock
// - page reads never wrap
module id_page_ctrl
    import id_page_pkg::*;
#(
    parameter int         WRITE_NS      = WRITE_CYCLE_NS,
    parameter logic [7:0] CMD_SET_LATCH = CMD_SET_LATCH_DEF,
    parameter logic [7:0] CMD_WRITE_ID  = CMD_WRITE_ID_DEF,
    parameter logic [7:0] CMD_READ_LOCK = CMD_READ_LOCK_DEF,
    parameter logic [7:0] CMD_LOCK_ID   = CMD_LOCK_ID_DEF,
    parameter logic [23:0] ID_CODE      = ID_CODE_DEF
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // supply monitor, asynchronous
    input  wire logic       por_active,
    // serial pins
    input  wire spi_in_s    spi_in,
    output logic            miso,
    output logic            miso_oe,
    // status register bits
    input  wire protect_s   protect,
    output status_s         status,
    // page read port for the array read path
    input  wire logic [6:0] page_rd_addr,
    output logic [7:0]      page_rd_data
);

    localparam int WR_RAW    = (WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYCLES = (WR_RAW < 1) ? 1 : WR_RAW;
    localparam int TMR_W     = $clog2(WR_CYCLES + 1);
    localparam logic [GROUP_BITS-1:0] ERASED_GRP = {GROUP_BYTES{ERASED_BYTE}};
    localparam logic [GROUP_BITS-1:0] ID_GRP     =
        {ERASED_BYTE, ID_CODE[7:0], ID_CODE[15:8], ID_CODE[23:16]};
    localparam logic [ECC_BITS-1:0] ECC_ERASED = ecc_gen(ERASED_GRP);
    localparam logic [ECC_BITS-1:0] ECC_ID     = ecc_gen(ID_GRP);

    // input synchronisers
    spi_in_s              spi_s1_r;
    spi_in_s              spi_s2_r;
    spi_in_s              spi_s3_r;
    logic                 por_s1_r;
    logic                 por_s2_r;

    // frame state
    logic                 frame_ok_r;
    logic [2:0]           bit_pos_r;
    logic [1:0]           hdr_r;
    logic                 data_seen_r;
    logic [6:0]           shift_r;
    logic [7:0]           opcode_r;
    logic [ADDR_BITS-1:0] addr_r;
    logic                 lock_arg_r;
    logic [6:0]           wr_ptr_r;

    // write buffer, storage and write cycle
    logic [7:0]           buf_r   [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_r;
    logic [GROUP_BITS-1:0] page_r [GROUPS];
    logic [ECC_BITS-1:0]  ecc_r   [GROUPS];
    logic [GROUP_BITS-1:0] page_nxt [GROUPS];
    logic                 latch_r;
    logic                 busy_r;
    logic                 kind_lock_r;
    logic [TMR_W-1:0]     tmr_r;
    logic                 locked_r;
    logic                 miso_r;
    logic                 oe_r;

    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic byte_done;
    logic [7:0] new_byte;
    logic is_wr_id;
    logic is_lock;
    logic rd_lock_on;
    logic can_write;
    logic start_wr;
    logic start_lock;
    logic latch_set;
    logic commit;
    logic [7:0] lock_byte;
    logic [GROUP_BITS-1:0] rd_grp;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            spi_s1_r <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
            spi_s2_r <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
            spi_s3_r <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
            por_s1_r <= 1'b1;
            por_s2_r <= 1'b1;
        end else begin
            spi_s1_r <= spi_in;
            spi_s2_r <= spi_s1_r;
            spi_s3_r <= spi_s2_r;
            por_s1_r <= por_active;
            por_s2_r <= por_s1_r;
        end
    end

    assign sck_rise  = spi_s2_r.sck & ~spi_s3_r.sck & ~spi_s2_r.cs_n;
    assign sck_fall  = ~spi_s2_r.sck & spi_s3_r.sck & ~spi_s2_r.cs_n;
    assign cs_fall   = ~spi_s2_r.cs_n & spi_s3_r.cs_n;
    assign cs_rise   = spi_s2_r.cs_n & ~spi_s3_r.cs_n;
    assign byte_done = sck_rise && frame_ok_r && (bit_pos_r == LAST_BIT);
    assign new_byte  = {shift_r, spi_s2_r.mosi};
    assign is_wr_id  = (opcode_r == CMD_WRITE_ID) && !addr_r[ADDR_SEL_BIT];
    assign is_lock   = (opcode_r == CMD_LOCK_ID) && addr_r[ADDR_SEL_BIT];
    assign rd_lock_on = frame_ok_r && (hdr_r == HDR_DATA)
                        && (opcode_r == CMD_READ_LOCK) && addr_r[ADDR_SEL_BIT];

    // a frame opened during a write cycle or power-on is dead to its end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            frame_ok_r  <= 1'b0;
            bit_pos_r   <= '0;
            hdr_r       <= '0;
            data_seen_r <= 1'b0;
            shift_r     <= '0;
            opcode_r    <= '0;
            addr_r      <= '0;
            lock_arg_r  <= 1'b0;
            wr_ptr_r    <= '0;
        end else if (por_s2_r || cs_rise) begin
            frame_ok_r  <= 1'b0;
            bit_pos_r   <= '0;
            hdr_r       <= '0;
            data_seen_r <= 1'b0;
        end else if (cs_fall) begin
            frame_ok_r  <= !busy_r;
        end else if (sck_rise && frame_ok_r) begin
            shift_r   <= new_byte[6:0];
            bit_pos_r <= bit_pos_r + 3'h1;
            if (byte_done) begin
                if (hdr_r != HDR_DATA) hdr_r <= hdr_r + 2'h1;
                case (hdr_r)
                    2'h0: opcode_r <= new_byte;
                    2'h1: addr_r[15:8] <= new_byte;
                    2'h2: begin
                        addr_r[7:0] <= new_byte;
                        wr_ptr_r    <= new_byte[6:0];
                    end
                    default: begin
                        data_seen_r <= 1'b1;
                        if (!data_seen_r) lock_arg_r <= new_byte[LOCK_ARG_BIT];
                        wr_ptr_r <= wr_ptr_r + 7'h01;
                    end
                endcase
            end
        end
    end

    // buffer holds the bytes of one write until the cycle ends
    always_ff @(posedge clk_sys) begin
        if (byte_done && hdr_r == HDR_DATA && is_wr_id) buf_r[wr_ptr_r] <= new_byte;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mask_r <= '0;
        end else if (por_s2_r || commit || (cs_fall && !busy_r)) begin
            mask_r <= '0;
        end else if (byte_done && hdr_r == HDR_DATA && is_wr_id) begin
            mask_r[wr_ptr_r] <= 1'b1;
        end
    end

    assign can_write = cs_rise && frame_ok_r && latch_r && !busy_r
                       && !(protect.block_protect_high && protect.block_protect_low)
                       && data_seen_r && (bit_pos_r == 3'h0);
    assign start_wr   = can_write && is_wr_id && !locked_r;
    assign start_lock = can_write && is_lock && lock_arg_r;
    assign latch_set  = cs_rise && frame_ok_r && (opcode_r == CMD_SET_LATCH)
                        && (hdr_r == 2'h1) && (bit_pos_r == 3'h0);
    assign commit     = busy_r && (tmr_r == '0);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_r      <= 1'b0;
            tmr_r       <= '0;
            kind_lock_r <= 1'b0;
        end else if (por_s2_r) begin
            busy_r      <= 1'b0;
            tmr_r       <= '0;
        end else if (start_wr || start_lock) begin
            busy_r      <= 1'b1;
            tmr_r       <= TMR_W'(WR_CYCLES - 1);
            kind_lock_r <= start_lock;
        end else if (busy_r) begin
            if (commit) busy_r <= 1'b0;
            else tmr_r <= tmr_r - TMR_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            latch_r <= 1'b0;
        end else if (por_s2_r || start_wr || start_lock) begin
            latch_r <= 1'b0;
        end else if (latch_set) begin
            latch_r <= 1'b1;
        end
    end

    // lock bit is one-way; nothing but the asynchronous reset clears it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            locked_r <= 1'b0;
        end else if (commit && kind_lock_r) begin
            locked_r <= 1'b1;
        end
    end

    // every written group is corrected and re-encoded as a whole
    always_comb begin
        logic [GROUP_BITS-1:0] fixed;
        fixed = '0;
        for (int g = 0; g < GROUPS; g++) begin
            fixed = ecc_fix(page_r[g], ecc_r[g]);
            for (int b = 0; b < GROUP_BYTES; b++) begin
                page_nxt[g][b*8 +: 8] = mask_r[g*GROUP_BYTES + b]
                                        ? buf_r[g*GROUP_BYTES + b] : fixed[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int g = 0; g < GROUPS; g++) begin
                page_r[g] <= (g == 0) ? ID_GRP : ERASED_GRP;
                ecc_r[g]  <= (g == 0) ? ECC_ID : ECC_ERASED;
            end
        end else if (commit && !kind_lock_r) begin
            for (int g = 0; g < GROUPS; g++) begin
                page_r[g] <= page_nxt[g];
                ecc_r[g]  <= ecc_gen(page_nxt[g]);
            end
        end
    end

    // read port address is seven bits wide, so it cannot leave the page
    assign rd_grp = ecc_fix(page_r[page_rd_addr[6:2]], ecc_r[page_rd_addr[6:2]]);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            page_rd_data <= '0;
        end else begin
            page_rd_data <= rd_grp[page_rd_addr[1:0]*8 +: 8];
        end
    end

    assign lock_byte = {7'h00, locked_r};

    // bit position wraps, so the same byte keeps coming out
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            miso_r <= 1'b0;
        end else if (sck_fall && rd_lock_on) begin
            miso_r <= lock_byte[LAST_BIT - bit_pos_r];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            oe_r <= 1'b0;
        end else if (spi_s2_r.cs_n || por_s2_r) begin
            oe_r <= 1'b0;
        end else if (sck_fall && rd_lock_on) begin
            oe_r <= 1'b1;
        end
    end

    // gating with select drops the driver in the very cycle select rises
    assign miso_oe = oe_r && !spi_s2_r.cs_n;
    assign miso    = miso_r;
    assign status  = '{write_enable_latch: latch_r, write_in_progress: busy_r,
                       page_locked: locked_r};

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_oe_when_deselected: assert property (
        spi_s2_r.cs_n |-> !miso_oe
    ) else $error("output driven while deselected");

    a_write_cycle_held: assert property (
        (start_wr || start_lock) |=> busy_r [*8]
    ) else $error("write cycle shorter than expected");

    a_protect_blocks: assert property (
        (cs_rise && !busy_r && protect.block_protect_high && protect.block_protect_low)
        |=> !busy_r
    ) else $error("write started with full protection");

    a_latch_needed: assert property (
        (cs_rise && !latch_r && !busy_r) |=> !busy_r
    ) else $error("write started without write latch");

    a_boundary_only: assert property (
        (cs_rise && !busy_r && bit_pos_r != 3'h0) |=> !busy_r
    ) else $error("command ran off a byte boundary");

    a_lock_sticky: assert property (
        locked_r |=> locked_r
    ) else $error("page lock was undone");

    a_busy_no_read: assert property (
        (cs_fall && busy_r) |=> (!miso_oe throughout (!cs_rise [*8]))
    ) else $error("lock state driven during write cycle");

    a_por_quiet: assert property (
        por_s2_r |=> (!busy_r && !latch_r && !frame_ok_r)
    ) else $error("instruction state alive during power-on");

    a_lock_bit_out: assert property (
        (sck_fall && rd_lock_on && bit_pos_r == LAST_BIT) |=> (miso == locked_r)
    ) else $error("lock bit not on last bit of status byte");

    a_latch_cleared: assert property (
        (start_wr || start_lock) |=> (!latch_r && busy_r)
    ) else $error("write latch not cleared at write start");

endmodule

// *** testbench/spi_master_model.sv ***
// spi bus master model driving select, clock and data
`timescale 1ns/100ps
module spi_master_model
    import id_page_pkg::*;
(
    // clock
    input  wire logic clk_sys,
    // serial pins
    input  wire logic miso,
    input  wire logic miso_oe,
    output spi_in_s   spi_in
);
    logic last_r = 1'b0;
    logic q_line;

    initial begin
        spi_in = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
    end

    // a released line shows the inverse of its last driven level
    always @(posedge clk_sys) begin
        if (miso_oe) last_r <= miso;
    end
    assign q_line = miso_oe ? miso : ~last_r;

    task automatic half();
        repeat (6) @(negedge clk_sys);
    endtask

    // sck stands low outside frames; mode 0, sample at sck rise
    task automatic xfer(input logic [63:0] tx, input int nbits,
                        output logic [63:0] rx, output logic oe);
        rx = '0;
        oe = 1'b0;
        @(negedge clk_sys);
        spi_in.cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_in.mosi = tx[i];
            half();
            spi_in.sck = 1'b1;
            rx = {rx[62:0], q_line};
            oe = miso_oe;
            half();
            spi_in.sck = 1'b0;
        end
        half();
        spi_in.cs_n = 1'b1;
        spi_in.mosi = ~spi_in.mosi;
        repeat (3) @(negedge clk_sys);
    endtask
endmodule

// *** testbench/id_page_ctrl_bench.sv ***
// bench for the id page command block
`timescale 1ns/100ps
module id_page_ctrl_bench
    import id_page_pkg::*;
;
    // short write cycle, yet long enough to outlast a lock read and a latch frame
    localparam int WNS  = 4000;
    localparam int WCYC = WNS / CLK_PERIOD_NS;

    logic        clk_sys;
    logic        arst_n;
    logic        por_active;
    spi_in_s     spi_in;
    logic        miso;
    logic        miso_oe;
    protect_s    protect;
    status_s     status;
    logic [6:0]  page_rd_addr;
    logic [7:0]  page_rd_data;
    int          err_total;
    int          num_checks;
    logic [63:0] rx;
    logic        oe;
    logic [15:0] busy_run;
    logic [15:0] busy_last;

    // length of the last busy stretch in clock cycles
    always @(posedge clk_sys) begin
        if (status.write_in_progress === 1'b1) begin
            busy_run <= busy_run + 16'h0001;
        end else begin
            busy_run <= 16'h0000;
            if (busy_run != 16'h0000) busy_last <= busy_run;
        end
    end

    id_page_ctrl #(.WRITE_NS(WNS)) uut (
        .clk_sys(clk_sys), .arst_n(arst_n), .por_active(por_active),
        .spi_in(spi_in), .miso(miso), .miso_oe(miso_oe), .protect(protect),
        .status(status), .page_rd_addr(page_rd_addr), .page_rd_data(page_rd_data)
    );

    spi_master_model master (
        .clk_sys(clk_sys), .miso(miso), .miso_oe(miso_oe), .spi_in(spi_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one frame, then the busy flag shows whether it was taken
    task automatic cmd(input logic [63:0] tx, input int nbits, input logic exp_wip);
        master.xfer(tx, nbits, rx, oe);
        repeat (6) @(negedge clk_sys);
        check("busy", status.write_in_progress, exp_wip);
    endtask

    task automatic wait_idle();
        for (int n = 0; n < WCYC + 50; n++) begin
            if (status.write_in_progress === 1'b0) begin
                @(negedge clk_sys);
                check("cycle len", busy_last, 16'(WCYC));
                return;
            end
            @(negedge clk_sys);
        end
        err_total++;
        stop_test();
    endtask

    task automatic rdpage(input logic [6:0] a, input logic [7:0] exp);
        page_rd_addr = a;
        @(negedge clk_sys);
        check("page byte", page_rd_data, exp);
    endtask

    // lock state read with two status bytes clocked out
    task automatic lockrd(input logic [15:0] exp, input logic exp_oe);
        master.xfer({8'h83, 16'h0400, 16'h0000}, 40, rx, oe);
        if (exp_oe) check("lock byte", rx[15:0], exp);
        check("drive", oe, exp_oe);
        check("release", miso_oe, 0);
    endtask

    initial begin
        arst_n = 1'b0;
        por_active = 1'b0;
        protect = '0;
        page_rd_addr = '0;
        err_total = 0;
        num_checks = 0;
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        check("status", status, 3'h0);
        rdpage(7'h00, ID_CODE_DEF[23:16]);
        rdpage(7'h03, ERASED_BYTE);
        lockrd(16'h0000, 1);
        cmd({8'h82, 16'h0005, 8'h11}, 32, 0);
        cmd(8'h06, 8, 0);
        check("latch", status.write_enable_latch, 1);
        // wrap from the last byte into byte zero
        cmd({8'h82, 16'h007F, 16'hA1B2}, 40, 1);
        check("latch", status.write_enable_latch, 0);
        lockrd(16'h0000, 0);
        cmd(8'h06, 8, 1);
        check("latch", status.write_enable_latch, 0);
        wait_idle();
        rdpage(7'h7F, 8'hA1);
        rdpage(7'h00, 8'hB2);
        rdpage(7'h01, ID_CODE_DEF[15:8]);
        rdpage(7'h7E, ERASED_BYTE);
        cmd(8'h06, 8, 0);
        protect = '1;
        cmd({8'h82, 16'h0010, 8'h55}, 32, 0);
        check("latch", status.write_enable_latch, 1);
        protect = '0;
        cmd({8'h82, 16'h0400, 8'h01}, 32, 0);
        // full argument byte, then two stray bits past the boundary
        cmd({8'h82, 16'h0400, 8'h02, 2'b00}, 34, 0);
        cmd({8'h82, 16'h0400, 8'h02}, 32, 1);
        wait_idle();
        check("locked", status.page_locked, 1);
        lockrd(16'h0101, 1);
        cmd(8'h06, 8, 0);
        cmd({8'h82, 16'h0001, 8'h77}, 32, 0);
        rdpage(7'h01, ID_CODE_DEF[15:8]);
        // supply monitor clears the latch and blocks frames
        por_active = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("latch", status.write_enable_latch, 0);
        cmd(8'h06, 8, 0);
        check("latch", status.write_enable_latch, 0);
        por_active = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("locked", status.page_locked, 1);
        stop_test();
    end
endmodule
